// ==== common/ebpwm_pkg.sv ====
// ebpwm_pkg: register map, field layout, reset values and timing counts of the bridge pwm generator.
// assumes a single 200 MHz system clock that is also the pwm oscillator clock.
package ebpwm_pkg;

  // timing: one oscillator period is one system clock, an instruction cycle is four of them
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TOSC_PS = 5000;
  localparam int unsigned CLK_PER_TOSC = (TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TOSC_PER_INSTR = 4;
  localparam int unsigned CLK_PER_INSTR = CLK_PER_TOSC * TOSC_PER_INSTR;

  // byte addresses on the register bus
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_HIGH = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_DEADBAND = 8'h10;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // pwm_control_reg fields
  localparam int unsigned CTL_MODE_LSB = 6;
  localparam int unsigned CTL_DUTY_LSB = 4;
  localparam int unsigned CTL_PWM_LSB = 2;
  localparam int unsigned CTL_POL_AC = 1;
  localparam int unsigned CTL_POL_BD = 0;
  localparam logic [1:0] CTL_PWM_ON = 2'h3;

  // period_timer_ctrl fields
  localparam int unsigned TCTL_RUN = 2;
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_4 = 2'h1;
  localparam logic [3:0] PRE_LIMIT_1 = 4'h0;
  localparam logic [3:0] PRE_LIMIT_4 = 4'h3;
  localparam logic [3:0] PRE_LIMIT_16 = 4'hF;

  // status layout: flag bit 0, timer 15:8, duty buffer 25:16
  localparam int unsigned STS_FLAG = 0;
  localparam int unsigned STS_TMR_LSB = 8;
  localparam int unsigned STS_DBUF_LSB = 16;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [2:0] RST_TIMER_CTRL = 3'h0;
  localparam logic [6:0] RST_DEADBAND = 7'h00;
  localparam logic [3:0] RST_PIN_DIR = 4'hF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_FULL_FWD = 2'b01,
    MODE_HALF = 2'b10,
    MODE_FULL_REV = 2'b11
  } ebpwm_mode_e;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] duty_high_byte;
    logic [7:0] period_reg;
    logic [2:0] period_timer_ctrl;
    logic [6:0] deadband_reg;
    logic [3:0] pin_dir;
    logic period_timer_flag;
    logic [1:0] q_cnt;
    logic [3:0] pre_cnt;
    logic [7:0] period_timer;
    logic [9:0] duty_buffer;
    logic pwm_raw;
    logic armed;
    logic en_d;
    logic [8:0] db_cnt;
    logic [3:0] pin_out;
    logic [3:0] pin_sel;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ebpwm_state_s;

endpackage

// ==== verilog/ebpwm_top.sv ====
// ebpwm_top: bridge pwm generator with an axi4-lite register slave.
// assumes i_sleep comes from the power controller on the same clock; pins are muxed outside.
`timescale 1ns/1ps

// Behaviour
// - timer prescaler divides by one, four or sixteen, scaling period and pulse width.
// - period is four oscillator periods times (period_reg+1) times prescale ratio.
// - pulse width is oscillator period times 10-bit duty times prescale ratio.
// - duty beyond the period leaves outputs set for the whole cycle.
// - in sleep the timer stops and the pwm engine state freezes; bus registers still take writes.
// - in sleep every bridge output keeps its level.
// - after wake the timer resumes from its held value.
// - timebase runs from the system clock, frequency tracks it.
// - reset sets all pins to input and registers to defaults.
// - mode field selects single 00, half 10, full forward 01, full reverse 11.
// - polarity bits make each output pair active-high or active-low.
// - on enable, waveform waits for the next full period start.
// - zero control releases all pins; unused pins stay free for other functions.
// - half-bridge drives modulated A and complement B; C and D unused.
// - half-bridge dead-band delays each active edge by count instruction cycles.
// - dead-band longer than the active time keeps that output inactive all cycle.
// - full forward holds A active, modulates D, B and C inactive.
// - full reverse holds C active, modulates B, A and D inactive.
// - after timer equals period: clear timer, set output unless duty zero, latch duty.
// - output clears when 10-bit timebase matches the buffered duty.
// - duty byte and low bits writable anytime, applied at next period boundary.
module ebpwm_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_sleep,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic o_bridge_out_a,
  output logic o_bridge_out_b,
  output logic o_bridge_out_c,
  output logic o_bridge_out_d,
  output logic [3:0] o_pin_pwm_sel,
  output logic [3:0] o_pin_oe,
  output logic o_period_timer_flag
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
    $error("ebpwm_top: ADDR_W must be 5..32");
  end

  ebpwm_pkg::ebpwm_state_s st_r;
  ebpwm_pkg::ebpwm_state_s st_nxt;

  // decoded configuration
  logic pwm_en;
  logic [1:0] mode;
  logic [9:0] duty_val;
  logic [9:0] timebase;
  logic [3:0] pre_limit;
  logic run;
  logic tick;
  logic boundary;
  logic [3:0] act;
  logic [3:0] use_mask;
  logic [3:0] low_mask;
  logic db_done;
  logic [8:0] db_target;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [7:0] rd_addr;

  always_comb begin
    pwm_en = (st_r.control[ebpwm_pkg::CTL_PWM_LSB +: 2] == ebpwm_pkg::CTL_PWM_ON);
    mode = st_r.control[ebpwm_pkg::CTL_MODE_LSB +: 2];
    duty_val = {st_r.duty_high_byte, st_r.control[ebpwm_pkg::CTL_DUTY_LSB +: 2]};
    run = st_r.period_timer_ctrl[ebpwm_pkg::TCTL_RUN];
    // prescale limit counts instruction cycles per timer increment
    case (st_r.period_timer_ctrl[1:0])
      ebpwm_pkg::PRESCALE_1: pre_limit = ebpwm_pkg::PRE_LIMIT_1;
      ebpwm_pkg::PRESCALE_4: pre_limit = ebpwm_pkg::PRE_LIMIT_4;
      default: pre_limit = ebpwm_pkg::PRE_LIMIT_16;
    endcase
    // one increment per instruction cycle times prescale, from the system clock
    tick = run && !i_sleep && (st_r.q_cnt == 2'h3) && (st_r.pre_cnt == pre_limit);
    boundary = tick && (st_r.period_timer == st_r.period_reg);
    db_target = {st_r.deadband_reg, 2'h0};
    db_done = (st_r.db_cnt >= db_target);
    low_mask = {st_r.control[ebpwm_pkg::CTL_POL_BD], st_r.control[ebpwm_pkg::CTL_POL_AC],
                st_r.control[ebpwm_pkg::CTL_POL_BD], st_r.control[ebpwm_pkg::CTL_POL_AC]};
    // act bit order d,c,b,a before polarity
    act = 4'h0;
    use_mask = 4'h0;
    if (pwm_en) begin
      case (mode)
        ebpwm_pkg::MODE_SINGLE: begin
          use_mask = 4'b0001;
          act = {3'b000, st_r.armed && st_r.pwm_raw};
        end
        ebpwm_pkg::MODE_HALF: begin
          use_mask = 4'b0011;
          act = {2'b00, st_r.armed && !st_r.pwm_raw && db_done,
                 st_r.armed && st_r.pwm_raw && db_done};
        end
        ebpwm_pkg::MODE_FULL_FWD: begin
          use_mask = 4'b1111;
          act = {st_r.armed && st_r.pwm_raw, 1'b0, 1'b0, st_r.armed};
        end
        ebpwm_pkg::MODE_FULL_REV: begin
          use_mask = 4'b1111;
          act = {1'b0, st_r.armed, st_r.armed && st_r.pwm_raw, 1'b0};
        end
        default: begin
          use_mask = 4'h0;
          act = 4'h0;
        end
      endcase
    end
  end

  // register read mux
  always_comb begin
    rd_addr = 8'h00;
    rd_addr[4:0] = i_s_axi_araddr[4:0];
    rd_hit = (i_s_axi_araddr[ADDR_W-1:5] == '0) && (i_s_axi_araddr[1:0] == 2'h0);
    rd_word = 32'h0000_0000;
    case (rd_addr)
      ebpwm_pkg::ADDR_CONTROL: rd_word[7:0] = st_r.control;
      ebpwm_pkg::ADDR_DUTY_HIGH: rd_word[7:0] = st_r.duty_high_byte;
      ebpwm_pkg::ADDR_PERIOD: rd_word[7:0] = st_r.period_reg;
      ebpwm_pkg::ADDR_TIMER_CTRL: rd_word[2:0] = st_r.period_timer_ctrl;
      ebpwm_pkg::ADDR_DEADBAND: rd_word[6:0] = st_r.deadband_reg;
      ebpwm_pkg::ADDR_PIN_DIR: rd_word[3:0] = st_r.pin_dir;
      ebpwm_pkg::ADDR_STATUS: begin
        rd_word[ebpwm_pkg::STS_FLAG] = st_r.period_timer_flag;
        rd_word[ebpwm_pkg::STS_TMR_LSB +: 8] = st_r.period_timer;
        rd_word[ebpwm_pkg::STS_DBUF_LSB +: 10] = st_r.duty_buffer;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    wbyte = st_r.wdata[7:0];
    wr_hit = 1'b0;
    timebase = 10'h000;

    // bus write: address and data taken in either order, answer once both held
    if (i_s_axi_awvalid && !st_r.aw_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = 8'h00;
      st_nxt.awaddr[4:0] = i_s_axi_awaddr[4:0];
      if (i_s_axi_awaddr[ADDR_W-1:5] != '0 || i_s_axi_awaddr[1:0] != 2'h0) begin
        st_nxt.awaddr = 8'hFF;
      end
    end
    if (i_s_axi_wvalid && !st_r.w_held && !st_r.bvalid) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = i_s_axi_wdata;
      st_nxt.wstrb = i_s_axi_wstrb;
    end
    if (st_r.bvalid && i_s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // pwm engine, frozen during sleep
    if (!i_sleep) begin
      if (run) begin
        st_nxt.q_cnt = st_r.q_cnt + 2'h1;
        if (st_r.q_cnt == 2'h3) begin
          st_nxt.pre_cnt = (st_r.pre_cnt == pre_limit) ? 4'h0 : st_r.pre_cnt + 4'h1;
        end
      end
      if (tick) begin
        st_nxt.period_timer = st_r.period_timer + 8'h01;
      end
      // match on the timebase this edge shows, else the registered compare adds a clock
      case (st_r.period_timer_ctrl[1:0])
        ebpwm_pkg::PRESCALE_1: timebase = {st_nxt.period_timer, st_nxt.q_cnt};
        ebpwm_pkg::PRESCALE_4: timebase = {st_nxt.period_timer, st_nxt.pre_cnt[1:0]};
        default: timebase = {st_nxt.period_timer, st_nxt.pre_cnt[3:2]};
      endcase
      if (timebase == st_r.duty_buffer) begin
        st_nxt.pwm_raw = 1'b0;
      end
      if (boundary) begin
        st_nxt.period_timer = 8'h00;
        st_nxt.q_cnt = 2'h0;
        st_nxt.pre_cnt = 4'h0;
        st_nxt.duty_buffer = duty_val;
        st_nxt.pwm_raw = (duty_val != 10'h000);
        st_nxt.period_timer_flag = 1'b1;
        if (pwm_en) begin
          st_nxt.armed = 1'b1;
        end
      end
      // edge of the modulated signal restarts dead-band timing for the other output
      if (st_nxt.pwm_raw != st_r.pwm_raw) begin
        st_nxt.db_cnt = 9'h000;
      end else if (st_r.db_cnt != 9'h1FF) begin
        st_nxt.db_cnt = st_r.db_cnt + 9'h001;
      end
      st_nxt.en_d = pwm_en;
      if (!pwm_en || !st_r.en_d) begin
        st_nxt.armed = boundary && pwm_en && st_r.en_d;
      end
      st_nxt.pin_out = act ^ (low_mask & use_mask);
      st_nxt.pin_sel = use_mask;
    end

    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      wr_hit = 1'b1;
      st_nxt.bresp = ebpwm_pkg::RESP_OKAY;
      if (st_r.wstrb[0]) begin
        case (st_r.awaddr)
          ebpwm_pkg::ADDR_CONTROL: st_nxt.control = wbyte;
          ebpwm_pkg::ADDR_DUTY_HIGH: st_nxt.duty_high_byte = wbyte;
          ebpwm_pkg::ADDR_PERIOD: st_nxt.period_reg = wbyte;
          ebpwm_pkg::ADDR_TIMER_CTRL: st_nxt.period_timer_ctrl = wbyte[2:0];
          ebpwm_pkg::ADDR_DEADBAND: st_nxt.deadband_reg = wbyte[6:0];
          ebpwm_pkg::ADDR_PIN_DIR: st_nxt.pin_dir = wbyte[3:0];
          ebpwm_pkg::ADDR_STATUS: begin
            // write one clears; a boundary in the same cycle wins
            if (wbyte[ebpwm_pkg::STS_FLAG] && !(boundary)) begin
              st_nxt.period_timer_flag = 1'b0;
            end
          end
          default: wr_hit = 1'b0;
        endcase
      end else begin
        case (st_r.awaddr)
          ebpwm_pkg::ADDR_CONTROL, ebpwm_pkg::ADDR_DUTY_HIGH, ebpwm_pkg::ADDR_PERIOD,
          ebpwm_pkg::ADDR_TIMER_CTRL, ebpwm_pkg::ADDR_DEADBAND, ebpwm_pkg::ADDR_PIN_DIR,
          ebpwm_pkg::ADDR_STATUS: wr_hit = 1'b1;
          default: wr_hit = 1'b0;
        endcase
      end
      if (!wr_hit) begin
        st_nxt.bresp = ebpwm_pkg::RESP_SLVERR;
      end
    end

    // bus read
    if (st_r.rvalid && i_s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? ebpwm_pkg::RESP_OKAY : ebpwm_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
      st_r.control <= ebpwm_pkg::RST_CONTROL;
      st_r.duty_high_byte <= ebpwm_pkg::RST_DUTY_HIGH;
      st_r.period_reg <= ebpwm_pkg::RST_PERIOD;
      st_r.period_timer_ctrl <= ebpwm_pkg::RST_TIMER_CTRL;
      st_r.deadband_reg <= ebpwm_pkg::RST_DEADBAND;
      st_r.pin_dir <= ebpwm_pkg::RST_PIN_DIR;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    o_s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    o_s_axi_wready = !st_r.w_held && !st_r.bvalid;
    o_s_axi_bvalid = st_r.bvalid;
    o_s_axi_bresp = st_r.bresp;
    o_s_axi_arready = !st_r.rvalid;
    o_s_axi_rvalid = st_r.rvalid;
    o_s_axi_rdata = st_r.rdata;
    o_s_axi_rresp = st_r.rresp;
    o_bridge_out_a = st_r.pin_out[0];
    o_bridge_out_b = st_r.pin_out[1];
    o_bridge_out_c = st_r.pin_out[2];
    o_bridge_out_d = st_r.pin_out[3];
    o_pin_pwm_sel = st_r.pin_sel;
    o_pin_oe = ~st_r.pin_dir;
    o_period_timer_flag = st_r.period_timer_flag;
  end

endmodule // ebpwm_top

// ==== testbench/ebpwm_top_sva.sv ====
// ebpwm_sva: port-level checks of the bridge pwm generator.
// assumes it is bound onto ebpwm_top and sees its ports only.
`timescale 1ns/1ps
module ebpwm_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_sleep,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic o_bridge_out_a,
  input wire logic o_bridge_out_b,
  input wire logic o_bridge_out_c,
  input wire logic o_bridge_out_d,
  input wire logic [3:0] o_pin_pwm_sel
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // flag left out: a status write may still clear it while asleep
  AST_SLEEP_HOLD: assert property ($past(i_sleep) && i_sleep |->
    $stable({o_bridge_out_a, o_bridge_out_b, o_bridge_out_c, o_bridge_out_d})) else $error("pins moved in sleep");
  AST_UNUSED_LOW: assert property (({o_bridge_out_d, o_bridge_out_c, o_bridge_out_b, o_bridge_out_a}
    & ~o_pin_pwm_sel) == 4'h0) else $error("unused pin driven");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken while busy");
  AST_AW_BLOCK: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while busy");
  AST_R_LAT: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read late");
  AST_B_LAT: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##[1:2] o_s_axi_bvalid) else $error("write response late");
endmodule // ebpwm_sva

bind ebpwm_top ebpwm_sva u_sva (.i_mclk, .i_arst_n, .i_sleep, .i_s_axi_awvalid, .o_s_axi_awready,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_bridge_out_a, .o_bridge_out_b,
  .o_bridge_out_c, .o_bridge_out_d, .o_pin_pwm_sel);

// ==== testbench/ebpwm_load.sv ====
// ebpwm_load: bridge switch drivers seen as loads; times the high phase and period of one pin.
// assumes pull-downs on every pin, so an undriven pin reads low.
`timescale 1ns/1ps
module ebpwm_load (
  input wire logic i_mclk,
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_oe,
  input wire logic [1:0] i_pick,
  output logic [15:0] o_high,
  output logic [15:0] o_period
);
  logic [3:0] pin;
  logic prev = 1'b0;
  logic [15:0] cnt = 16'h0000;
  assign pin = i_out & i_oe;
  initial o_high = 16'h0000;
  initial o_period = 16'h0000;
  always @(posedge i_mclk) begin
    cnt <= cnt + 16'h0001;
    prev <= pin[i_pick];
    if (pin[i_pick] && !prev) begin
      o_period <= cnt;
      cnt <= 16'h0001;
    end
    if (!pin[i_pick] && prev) o_high <= cnt;
  end
endmodule // ebpwm_load

// ==== testbench/tb.sv ====
// tb: self-checking bench for the bridge pwm generator over axi4-lite.
// assumes ebpwm_top, its checker bind and the ebpwm_load model are compiled first.
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sleep = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] pick = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, flag;
  logic [1:0] bresp, rresp, ws, rs;
  logic [31:0] rdata, rd, snap;
  logic [3:0] outs, sel, oe;
  logic [15:0] hi_len, per_len;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  ebpwm_top dut (.i_mclk, .i_arst_n, .i_sleep, .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_bridge_out_a(outs[0]),
    .o_bridge_out_b(outs[1]), .o_bridge_out_c(outs[2]), .o_bridge_out_d(outs[3]), .o_pin_pwm_sel(sel),
    .o_pin_oe(oe), .o_period_timer_flag(flag));
  ebpwm_load load (.i_mclk, .i_out(outs), .i_oe(oe), .i_pick(pick), .o_high(hi_len), .o_period(per_len));
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ready is read mid-cycle, the transfer happens at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ga, gw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge i_mclk);
      ga = awvalid && awready;
      gw = wvalid && wready;
      @(posedge i_mclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      ta = ta || ga;
      tw = tw || gw;
    end
    bready <= 1'b1;
    do @(negedge i_mclk); while (bvalid !== 1'b1);
    ws = bresp;
    @(posedge i_mclk);
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic g;
    g = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!g) begin
      @(negedge i_mclk);
      g = arready;
      @(posedge i_mclk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge i_mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge i_mclk);
    rready <= 1'b0;
  endtask
  task automatic t_reset;
    chk({oe, sel, outs, flag}, 32'h0000_0000);
    rd_reg(ebpwm_pkg::ADDR_PERIOD);
    chk(rd, 32'h0000_00FF);
    rd_reg(ebpwm_pkg::ADDR_PIN_DIR);
    chk(rd, 32'h0000_000F);
    rd_reg(8'h1C);
    chk(rs, ebpwm_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h0000_0001);
    chk(ws, ebpwm_pkg::RESP_SLVERR);
    // low byte strobe off: answered okay, register untouched
    wstrb <= 4'h0;
    wr(ebpwm_pkg::ADDR_PERIOD, 32'h0000_0055);
    chk(ws, ebpwm_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd_reg(ebpwm_pkg::ADDR_PERIOD);
    chk(rd, 32'h0000_00FF);
  endtask
  // pins may only be driven once a fresh period has begun
  task automatic wait_flag;
    wr(ebpwm_pkg::ADDR_STATUS, 32'h0000_0001);
    n = 0;
    while (flag !== 1'b1 && n < 200) begin
      @(posedge i_mclk);
      n++;
    end
    chk(flag, 1'b1);
  endtask
  task automatic t_single;
    wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_000F);
    wr(ebpwm_pkg::ADDR_PERIOD, 32'h0000_0003);
    wr(ebpwm_pkg::ADDR_CONTROL, 32'h0000_002C);
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_0001);
    wr(ebpwm_pkg::ADDR_STATUS, 32'h0000_0001);
    wr(ebpwm_pkg::ADDR_TIMER_CTRL, 32'h0000_0004);
    n = 0;
    while (flag !== 1'b1 && n < 2000) begin
      @(posedge i_mclk);
      n++;
    end
    chk(flag, 1'b1);
    wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_000E);
    repeat (40) @(posedge i_mclk);
    chk(per_len, 32'h0000_0010);
    chk(hi_len, 32'h0000_0006);
    chk({sel, oe}, 32'h0000_0011);
    wr(ebpwm_pkg::ADDR_TIMER_CTRL, 32'h0000_0005);
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_0002);
    repeat (160) @(posedge i_mclk);
    chk(per_len, 32'h0000_0040);
    chk(hi_len, 32'h0000_0028);
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_00FF);
    repeat (160) @(posedge i_mclk);
    n = 0;
    repeat (64) begin
      @(posedge i_mclk);
      n += (outs[0] !== 1'b1);
    end
    chk(n, 32'h0000_0000);
    i_sleep <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rd_reg(ebpwm_pkg::ADDR_STATUS);
    snap = rd;
    repeat (40) @(posedge i_mclk);
    rd_reg(ebpwm_pkg::ADDR_STATUS);
    chk(rd, snap);
    chk(outs[0], 1'b1);
    i_sleep <= 1'b0;
    rd_reg(ebpwm_pkg::ADDR_STATUS);
    chk(((rd[15:8] - snap[15:8]) & 8'h03) <= 8'h01, 1'b1);
  endtask
  // mode and polarity take the same two-bit value, so every pass after the first also flips polarity
  task automatic t_modes;
    logic [1:0] p;
    logic [3:0] sx [4] = '{4'h1, 4'hF, 4'h3, 4'hF};
    logic [1:0] pk [4] = '{2'h0, 2'h3, 2'h0, 2'h1};
    wr(ebpwm_pkg::ADDR_TIMER_CTRL, 32'h0000_0004);
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_0003);
    for (int m = 0; m < 4; m++) begin
      p = m[1:0];
      wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_000F);
      wr(ebpwm_pkg::ADDR_CONTROL, {24'h00_0000, p, 2'h0, 2'h3, p});
      wait_flag();
      wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_0000);
      pick <= pk[m];
      repeat (48) @(posedge i_mclk);
      chk(sel, sx[m]);
      chk(hi_len, ((pk[m][0] ? p[0] : p[1]) ? 32'h0000_0004 : 32'h0000_000C));
      n = 0;
      repeat (16) begin
        @(posedge i_mclk);
        n += (outs[0] === outs[1]);
      end
      if (m == 2) chk(n, 32'h0000_0010);
      if (m == 1) chk(outs[2:0], {p[1], p[0], ~p[1]});
      if (m == 3) chk({outs[3], outs[2], outs[0]}, {p[0], ~p[1], p[1]});
    end
  endtask
  task automatic t_dead;
    wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_000F);
    wr(ebpwm_pkg::ADDR_CONTROL, 32'h0000_008C);
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_0002);
    wr(ebpwm_pkg::ADDR_DEADBAND, 32'h0000_0001);
    wait_flag();
    wr(ebpwm_pkg::ADDR_PIN_DIR, 32'h0000_0000);
    pick <= 2'h0;
    repeat (48) @(posedge i_mclk);
    chk(hi_len, 32'h0000_0004);
    pick <= 2'h1;
    repeat (48) @(posedge i_mclk);
    chk(hi_len, 32'h0000_0004);
    wr(ebpwm_pkg::ADDR_DEADBAND, 32'h0000_0003);
    repeat (48) @(posedge i_mclk);
    n = 0;
    repeat (32) begin
      @(posedge i_mclk);
      n += (outs[0] === 1'b1);
    end
    chk(n, 32'h0000_0000);
    wr(ebpwm_pkg::ADDR_CONTROL, 32'h0000_0000);
    repeat (4) @(posedge i_mclk);
    chk({sel, outs}, 32'h0000_0000);
  endtask
  // raw pwm is left high and the timer stopped, so only arming keeps the pin quiet
  task automatic t_arm;
    wr(ebpwm_pkg::ADDR_DUTY_HIGH, 32'h0000_003F);
    repeat (40) @(posedge i_mclk);
    wr(ebpwm_pkg::ADDR_TIMER_CTRL, 32'h0000_0000);
    wr(ebpwm_pkg::ADDR_CONTROL, 32'h0000_000C);
    repeat (8) @(posedge i_mclk);
    chk({sel, outs}, 32'h0000_0010);
    wr(ebpwm_pkg::ADDR_TIMER_CTRL, 32'h0000_0004);
    repeat (40) @(posedge i_mclk);
    chk({sel, outs}, 32'h0000_0011);
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    t_reset();
    t_single();
    t_modes();
    t_dead();
    t_arm();
    stop_test();
  end
endmodule // tb
